// >>> rtl/bzd_pkg.sv
/*
 * Constants, types and the register map of the zone decoder.
 * Assumes one 100 MHz clock and a synchronous active-low reset.
 */
// Contract
// R1: Pins 111 pick internal-ROM mode, or programming mode when flash is blank.
// R2: Pins 011 pick external-ROM mode, or programming mode when flash is blank.
// R3: Pins 110 always pick in-system-programming mode.
// R4: Pins 000 pick debug-external, 001 debug-internal; blank flags ignored.
// R5: Mode comes from boot pins at reset plus the flash-blank flags.
// R6: Debug-external disables flash; static zone 0 goes to the external bus.
// R7: Debug-internal is like debug-external but zone 0 stays on-chip.
// R8: 00_0000h to 03_FFFFh is on-chip flash in static zone 0.
// R9: 40_0000h to 7F_FFFFh is external memory with zone 1 timing.
// R10: 80_0000h to FE_FFFFh is external memory with zone 2 timing.
// R11: Configured timing applies to flash and I/O zone FF_FB00h-FF_FBFFh; this design ignores the fast-read bit in the I/O zone.
// R12: The master never accesses unlisted, reserved address ranges.
// R13: Normal read lasts two clocks, fast read one clock.
// R14: Normal reads are used after reset until software picks fast reads.
// R15: Late write lasts two clocks, early write three clocks.
// R16: Early writes are used after reset until software changes it.
// R17: Software switches to late writes after reset.
// R18: Wait cycles go right after the address is driven.
// R19: Hold cycles go at the end, keeping data driven.
// R20: Software programs the fewest wait and hold cycles the clock allows.
// R21: Five config registers at FF_F900h to FF_F908h.
// R22: Cycle type follows direction, zone and programmed timing selections.
// R23: General register resets to 07h; bit 0 set is early write.
// R24: Wait field adds 0 to 7 waits; hold field adds 0 to 3 holds.
// R25: Mode is latched once at reset release and then held.
package bzd_pkg;
	localparam logic [23:0] REG_GEN_ADDR    = 24'hfff900;
	localparam logic [23:0] REG_IOZ_ADDR    = 24'hfff902;
	localparam logic [23:0] REG_SZ0_ADDR    = 24'hfff904;
	localparam logic [23:0] REG_SZ1_ADDR    = 24'hfff906;
	localparam logic [23:0] REG_SZ2_ADDR    = 24'hfff908;
	localparam logic [23:0] REG_STATUS_ADDR = 24'hfff90a;
	localparam logic [7:0]  GEN_RST         = 8'h07;
	localparam logic [15:0] ZCFG_RST        = 16'h069f;
	localparam int          EARLY_WR_BIT    = 0;
	localparam int          WAIT_LSB        = 0;
	localparam int          HOLD_LSB        = 3;
	localparam int          FRE_BIT         = 11;
	localparam int          BUSY_BIT        = 8;
	localparam logic [23:0] Z0_LO   = 24'h000000;
	localparam logic [23:0] Z0_HI   = 24'h03ffff;
	localparam logic [23:0] Z0D_LO  = 24'h0d0000;
	localparam logic [23:0] Z0D_HI  = 24'h0d1fff;
	localparam logic [23:0] Z1_LO   = 24'h400000;
	localparam logic [23:0] Z1_HI   = 24'h7fffff;
	localparam logic [23:0] Z2_LO   = 24'h800000;
	localparam logic [23:0] Z2_HI   = 24'hfeffff;
	localparam logic [23:0] IO_LO   = 24'hfffb00;
	localparam logic [23:0] IO_HI   = 24'hfffbff;
	localparam logic [2:0]  BOOT_INT_ROM = 3'h7;
	localparam logic [2:0]  BOOT_EXT_ROM = 3'h3;
	localparam logic [2:0]  BOOT_PROG    = 3'h6;
	localparam logic [2:0]  BOOT_DEVEXT  = 3'h0;
	localparam logic [2:0]  BOOT_DBG_INT = 3'h1;
	localparam logic [1:0]  RD_FAST_CYC   = 2'h1;
	localparam logic [1:0]  RD_NORMAL_CYC = 2'h2;
	localparam logic [1:0]  WR_LATE_CYC   = 2'h2;
	localparam logic [1:0]  WR_EARLY_CYC  = 2'h3;
	typedef enum logic [4:0] {
		MODE_INT_ROM = 5'h01,
		MODE_EXT_ROM = 5'h02,
		MODE_DEVEXT  = 5'h04,
		MODE_DBG_INT = 5'h08,
		MODE_PROG    = 5'h10
	} bzd_mode_e;
	typedef enum logic [4:0] {
		ZONE_S0   = 5'h01,
		ZONE_S1   = 5'h02,
		ZONE_S2   = 5'h04,
		ZONE_IO   = 5'h08,
		ZONE_NONE = 5'h10
	} bzd_zone_e;
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_ADDR = 5'h02,
		PH_WAIT = 5'h04,
		PH_DATA = 5'h08,
		PH_HOLD = 5'h10
	} bzd_phase_e;
endpackage

// >>> rtl/bzd_dec_if.sv
/*
 * Carrier between the bus engine and the address decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
interface bzd_dec_if;
	import bzd_pkg::*;
	logic [23:0] addr;
	bzd_mode_e   mode;
	bzd_zone_e   zone;
	logic        to_ext;
	modport dec  (input addr, input mode, output zone, output to_ext);
	modport user (output addr, output mode, input zone, input to_ext);
endinterface
`default_nettype wire

// >>> rtl/bzd_decode.sv
/*
 * Combinational zone decoder of the 16 Mbyte space.
 * Assumes the mode input is already latched and stable.
 */
`timescale 1ns/100ps
`default_nettype none
module bzd_decode
	import bzd_pkg::*;
(
	bzd_dec_if.dec dec
);
	always_comb begin
		dec.zone = ZONE_NONE;
		if ((dec.addr >= Z0_LO && dec.addr <= Z0_HI) ||
			(dec.addr >= Z0D_LO && dec.addr <= Z0D_HI)) begin
			dec.zone = ZONE_S0;   // [R8]
		end else if (dec.addr >= Z1_LO && dec.addr <= Z1_HI) begin
			dec.zone = ZONE_S1;   // [R9]
		end else if (dec.addr >= Z2_LO && dec.addr <= Z2_HI) begin
			dec.zone = ZONE_S2;   // [R10]
		end else if (dec.addr >= IO_LO && dec.addr <= IO_HI) begin
			dec.zone = ZONE_IO;   // [R11]
		end
		// Zone 0 leaves the chip only in debug-external mode
		dec.to_ext = (dec.zone != ZONE_S0) ||
			(dec.mode == MODE_DEVEXT);   // [R6] [R7]
		if (dec.zone == ZONE_IO) begin
			dec.to_ext = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bzd_top.sv
/*
 * Bus interface unit: zone decode, boot mode and bus cycle timing.
 * Assumes a core that waits for CORE_DONE before its next request.
 */
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module bzd_top
	import bzd_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic [23:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	input  wire logic [2:0]  BOOT_SELECT_PINS,
	input  wire logic        FLASH_BLANK,
	output logic      [4:0]  OPER_MODE,
	input  wire logic        CORE_REQ,
	input  wire logic        CORE_WRITE,
	input  wire logic [23:0] CORE_ADDR,
	input  wire logic [15:0] CORE_WDATA,
	output logic      [15:0] CORE_RDATA,
	output logic             CORE_DONE,
	output logic             CORE_ERR,
	output logic             CORE_BUSY,
	output logic      [23:0] MEM_ADDR,
	output logic      [15:0] MEM_WDATA,
	input  wire logic [15:0] MEM_RDATA,
	output logic             MEM_RD_EN,
	output logic             MEM_WR_EN,
	output logic             MEM_CS_FLASH,
	output logic             MEM_CS_EXT,
	output logic             MEM_CS_IO
);
	typedef struct packed {
		bzd_phase_e  phase;
		bzd_mode_e   mode;
		logic        mode_ok;
		logic [2:0]  cnt;
		logic [1:0]  base;
		logic [1:0]  holds;
		logic        write;
		logic [7:0]  gen;
		logic [15:0] ioz;
		logic [15:0] sz0;
		logic [15:0] sz1;
		logic [15:0] sz2;
		logic [15:0] reg_rdata;
		logic [15:0] rdata;
		logic        done;
		logic        err;
		logic        busy;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic        rd_en;
		logic        wr_en;
		logic        cs_flash;
		logic        cs_ext;
		logic        cs_io;
	} bzd_state_s;

	bzd_state_s  st;
	bzd_state_s  next_st;
	bzd_dec_if   dec_bus ();
	logic [15:0] cfg;
	logic        acc;
	logic        fast;
	logic [2:0]  waits;
	logic        fin;
	bzd_mode_e   boot_mode;

	assign dec_bus.addr = CORE_ADDR;
	assign dec_bus.mode = st.mode;

	bzd_decode u_decode (
		.dec (dec_bus)
	);

	// Boot mode from pins and blank flags
	always_comb begin
		case (BOOT_SELECT_PINS)
			BOOT_INT_ROM: boot_mode = FLASH_BLANK ?
				MODE_PROG : MODE_INT_ROM;                   // [R1]
			BOOT_EXT_ROM: boot_mode = FLASH_BLANK ?
				MODE_PROG : MODE_EXT_ROM;                   // [R2]
			BOOT_PROG:    boot_mode = MODE_PROG;            // [R3]
			BOOT_DEVEXT:  boot_mode = MODE_DEVEXT;          // [R4]
			BOOT_DBG_INT: boot_mode = MODE_DBG_INT;         // [R4]
			default:      boot_mode = MODE_PROG;
		endcase
	end

	// Timing set of the addressed zone
	always_comb begin
		case (dec_bus.zone)
			ZONE_S0: cfg = st.sz0;
			ZONE_S1: cfg = st.sz1;
			ZONE_S2: cfg = st.sz2;
			ZONE_IO: cfg = st.ioz;
			default: cfg = 16'h0000;
		endcase
	end

	assign acc   = CORE_REQ && st.phase == PH_IDLE &&
		dec_bus.zone != ZONE_NONE;
	assign fast  = !CORE_WRITE && cfg[FRE_BIT] &&
		dec_bus.zone != ZONE_IO;                          // [R14]
	assign waits = fast ? 3'h0 : cfg[WAIT_LSB +: 3];          // [R24]

	always_comb begin
		next_st = st;
		fin = 1'b0;
		next_st.done = 1'b0;
		next_st.err = 1'b0;
		next_st.reg_rdata = 16'h0000;
		// Mode is caught once, in the first cycle out of reset
		if (!st.mode_ok) begin
			next_st.mode = boot_mode;                          // [R5]
			next_st.mode_ok = 1'b1;                            // [R25]
		end
		if (REG_WR) begin
			case (REG_ADDR)                                    // [R21]
				REG_GEN_ADDR:   next_st.gen = REG_WDATA[7:0];
				REG_IOZ_ADDR:   next_st.ioz = REG_WDATA;
				REG_SZ0_ADDR:   next_st.sz0 = REG_WDATA;
				REG_SZ1_ADDR:   next_st.sz1 = REG_WDATA;
				REG_SZ2_ADDR:   next_st.sz2 = REG_WDATA;
				default: ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				REG_GEN_ADDR:    next_st.reg_rdata = {8'h00, st.gen};
				REG_IOZ_ADDR:    next_st.reg_rdata = st.ioz;
				REG_SZ0_ADDR:    next_st.reg_rdata = st.sz0;
				REG_SZ1_ADDR:    next_st.reg_rdata = st.sz1;
				REG_SZ2_ADDR:    next_st.reg_rdata = st.sz2;
				REG_STATUS_ADDR: begin
					next_st.reg_rdata[4:0] = st.mode;
					next_st.reg_rdata[BUSY_BIT] = st.busy;
				end
				default: ;
			endcase
		end
		case (st.phase)
			PH_IDLE: begin
				if (acc) begin                                 // [R22]
					next_st.phase = PH_ADDR;
					next_st.cnt = waits;
					next_st.holds = fast ? 2'h0 : cfg[HOLD_LSB +: 2]; // [R24]
					if (CORE_WRITE) begin
						next_st.base = st.gen[EARLY_WR_BIT] ?
							WR_EARLY_CYC : WR_LATE_CYC;        // [R15] [R23]
					end else begin
						next_st.base = fast ?
							RD_FAST_CYC : RD_NORMAL_CYC;       // [R13]
					end
					next_st.write = CORE_WRITE;
					next_st.addr = CORE_ADDR;
					next_st.wdata = CORE_WDATA;
					next_st.busy = 1'b1;
					next_st.rd_en = !CORE_WRITE;
					next_st.cs_flash = dec_bus.zone == ZONE_S0 &&
						!dec_bus.to_ext;                       // [R7]
					next_st.cs_ext = dec_bus.to_ext;           // [R6] [R9] [R10]
					next_st.cs_io = dec_bus.zone == ZONE_IO;   // [R11]
				end else if (CORE_REQ && st.phase == PH_IDLE) begin
					next_st.done = 1'b1;
					next_st.err = 1'b1;
				end
			end
			PH_ADDR: begin
				if (st.cnt != 3'h0) begin
					next_st.phase = PH_WAIT;                   // [R18]
					next_st.cnt = st.cnt - 3'h1;
				end else if (st.base == RD_FAST_CYC) begin
					next_st.rdata = MEM_RDATA;                 // [R13]
					fin = 1'b1;
				end else begin
					next_st.phase = PH_DATA;
					next_st.cnt = {1'b0, st.base - 2'h2};
					next_st.wr_en = st.write;
				end
			end
			PH_WAIT: begin
				if (st.cnt != 3'h0) begin
					next_st.cnt = st.cnt - 3'h1;               // [R18]
				end else begin
					next_st.phase = PH_DATA;
					next_st.cnt = {1'b0, st.base - 2'h2};
					next_st.wr_en = st.write;
				end
			end
			PH_DATA: begin
				if (st.cnt != 3'h0) begin
					next_st.cnt = st.cnt - 3'h1;
				end else begin
					if (!st.write) begin
						next_st.rdata = MEM_RDATA;
					end
					next_st.rd_en = 1'b0;
					next_st.wr_en = 1'b0;
					if (st.holds != 2'h0) begin
						next_st.phase = PH_HOLD;               // [R19]
						next_st.cnt = {1'b0, st.holds - 2'h1};
					end else begin
						fin = 1'b1;
					end
				end
			end
			PH_HOLD: begin
				if (st.cnt != 3'h0) begin
					next_st.cnt = st.cnt - 3'h1;               // [R19]
				end else begin
					fin = 1'b1;
				end
			end
			default: begin
				next_st.phase = PH_IDLE;
			end
		endcase
		if (fin) begin
			next_st.phase = PH_IDLE;
			next_st.done = 1'b1;
			next_st.busy = 1'b0;
			next_st.rd_en = 1'b0;
			next_st.wr_en = 1'b0;
			next_st.cs_flash = 1'b0;
			next_st.cs_ext = 1'b0;
			next_st.cs_io = 1'b0;
		end
		if (!RST_N) begin
			next_st = '0;
			next_st.phase = PH_IDLE;
			next_st.mode = MODE_PROG;
			next_st.gen = GEN_RST;                             // [R16] [R23]
			next_st.ioz = ZCFG_RST;
			next_st.sz0 = ZCFG_RST;                            // [R14]
			next_st.sz1 = ZCFG_RST;
			next_st.sz2 = ZCFG_RST;
		end
	end

	always_ff @(posedge CLOCK) begin
		st <= next_st;
	end

	assign REG_RDATA    = st.reg_rdata;
	assign OPER_MODE    = st.mode;
	assign CORE_RDATA   = st.rdata;
	assign CORE_DONE    = st.done;
	assign CORE_ERR     = st.err;
	assign CORE_BUSY    = st.busy;
	assign MEM_ADDR     = st.addr;
	assign MEM_WDATA    = st.wdata;
	assign MEM_RD_EN    = st.rd_en;
	assign MEM_WR_EN    = st.wr_en;
	assign MEM_CS_FLASH = st.cs_flash;
	assign MEM_CS_EXT   = st.cs_ext;
	assign MEM_CS_IO    = st.cs_io;

	logic plain;
	logic io_hit;
	assign plain = acc && !fast && waits == 3'h0 &&
		cfg[HOLD_LSB +: 2] == 2'h0;
	assign io_hit = dec_bus.zone == ZONE_IO;

	property p_mode_hold;
		@(posedge CLOCK) disable iff (!RST_N)
		st.mode_ok |=> $stable(OPER_MODE);
	endproperty
	a_mode_hold: assert property (p_mode_hold) // [R25]
		else $error("mode changed after latch");

	property p_boot_ire;
		@(posedge CLOCK) disable iff (!RST_N)
		RST_N && !st.mode_ok && BOOT_SELECT_PINS == 3'h7 && !FLASH_BLANK
		|=> OPER_MODE == MODE_INT_ROM ##1 OPER_MODE == MODE_INT_ROM;
	endproperty
	a_boot_ire: assert property (p_boot_ire) // [R1]
		else $error("internal rom mode not chosen");

	property p_boot_isp;
		@(posedge CLOCK) disable iff (!RST_N)
		RST_N && !st.mode_ok && (BOOT_SELECT_PINS == 3'h6 ||
		(BOOT_SELECT_PINS == 3'h3 && FLASH_BLANK))
		|=> OPER_MODE == MODE_PROG;
	endproperty
	a_boot_isp: assert property (p_boot_isp) // [R3]
		else $error("programming mode not chosen");

	property p_boot_dev;
		@(posedge CLOCK) disable iff (!RST_N)
		RST_N && !st.mode_ok && BOOT_SELECT_PINS == 3'h0
		|=> OPER_MODE == MODE_DEVEXT;
	endproperty
	a_boot_dev: assert property (p_boot_dev) // [R4]
		else $error("debug external mode not chosen");

	property p_fast_read;
		@(posedge CLOCK) disable iff (!RST_N)
		acc && fast |=> !CORE_DONE ##1 CORE_DONE && !CORE_BUSY;
	endproperty
	a_fast_read: assert property (p_fast_read) // [R13]
		else $error("fast read not one clock");

	property p_norm_read;
		@(posedge CLOCK) disable iff (!RST_N)
		plain && !CORE_WRITE |=> !CORE_DONE [*2] ##1 CORE_DONE;
	endproperty
	a_norm_read: assert property (p_norm_read) // [R13]
		else $error("normal read not two clocks");

	property p_late_write;
		@(posedge CLOCK) disable iff (!RST_N)
		plain && CORE_WRITE && !st.gen[0] |=> !CORE_DONE [*2] ##1 CORE_DONE;
	endproperty
	a_late_write: assert property (p_late_write) // [R15]
		else $error("late write not two clocks");

	property p_early_write;
		@(posedge CLOCK) disable iff (!RST_N)
		plain && CORE_WRITE && st.gen[0] |=> !CORE_DONE [*3] ##1 CORE_DONE;
	endproperty
	a_early_write: assert property (p_early_write) // [R15]
		else $error("early write not three clocks");

	property p_wait_pos;
		@(posedge CLOCK) disable iff (!RST_N)
		acc && waits == 3'h2 |=> ##1 !MEM_WR_EN [*2] ##1 MEM_CS_EXT ||
		MEM_CS_FLASH || MEM_CS_IO;
	endproperty
	a_wait_pos: assert property (p_wait_pos) // [R18]
		else $error("wait cycles not after address");

	property p_hold_data;
		@(posedge CLOCK) disable iff (!RST_N)
		st.phase == PH_HOLD |-> $stable(MEM_WDATA) && !MEM_WR_EN &&
		(MEM_CS_EXT || MEM_CS_FLASH || MEM_CS_IO);
	endproperty
	a_hold_data: assert property (p_hold_data) // [R19]
		else $error("hold cycle lost the bus");

	property p_dev_ext;
		@(posedge CLOCK) disable iff (!RST_N)
		acc && dec_bus.zone == ZONE_S0 && st.mode == MODE_DEVEXT
		|=> MEM_CS_EXT && !MEM_CS_FLASH;
	endproperty
	a_dev_ext: assert property (p_dev_ext) // [R6]
		else $error("zone 0 not external in debug mode");

	property p_zone_sel;
		@(posedge CLOCK) disable iff (!RST_N)
		acc |=> MEM_CS_IO == $past(io_hit);
	endproperty
	a_zone_sel: assert property (p_zone_sel) // [R11]
		else $error("io zone select wrong");
endmodule
`default_nettype wire

// >>> tb/bzd_mem_model.sv
/*
 * Behavioural static memory on the far side of the bus unit.
 * Assumes the unit's registered strobes and the one shared clock.
 */
`timescale 1ns/100ps
`default_nettype none
module bzd_mem_model (
	input  wire logic        clock,
	input  wire logic [23:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic        mem_rd_en,
	input  wire logic        mem_wr_en,
	output logic      [15:0] mem_rdata
);
	logic [15:0] idle_pat = 16'h0f0f;
	logic [15:0] last_wdata = 16'h0000;
	// Released bus toggles each cycle so stale data never passes
	assign mem_rdata = mem_rd_en ? (mem_addr[15:0] ^ 16'h5a5a) : idle_pat;
	always @(posedge clock) begin
		idle_pat <= ~idle_pat;
		if (mem_wr_en) begin
			last_wdata <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

// >>> tb/bus_interface_zone_decoder_tb.sv
/*
 * Self-checking bench of the zone decoder and bus cycle timing.
 * Assumes the design package and a memory model on the far side.
 */
`timescale 1ns/100ps
`default_nettype none
module bus_interface_zone_decoder_tb;
	import bzd_pkg::*;
	logic        CLOCK = 1'b0;
	logic        RST_N = 1'b0;
	logic [23:0] REG_ADDR = 24'h000000;
	logic [15:0] REG_WDATA = 16'h0000;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [2:0]  BOOT_SELECT_PINS = 3'h7;
	logic        FLASH_BLANK = 1'b0;
	logic        CORE_REQ = 1'b0;
	logic        CORE_WRITE = 1'b0;
	logic [23:0] CORE_ADDR = 24'h000000;
	logic [15:0] CORE_WDATA = 16'h0000;
	wire  [15:0] REG_RDATA;
	wire  [4:0]  OPER_MODE;
	wire  [15:0] CORE_RDATA;
	wire         CORE_DONE;
	wire         CORE_ERR;
	wire         CORE_BUSY;
	wire  [23:0] MEM_ADDR;
	wire  [15:0] MEM_WDATA;
	wire  [15:0] MEM_RDATA;
	wire         MEM_RD_EN;
	wire         MEM_WR_EN;
	wire         MEM_CS_FLASH;
	wire         MEM_CS_EXT;
	wire         MEM_CS_IO;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #5 CLOCK = ~CLOCK;

	bzd_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .BOOT_SELECT_PINS(BOOT_SELECT_PINS),
		.FLASH_BLANK(FLASH_BLANK), .OPER_MODE(OPER_MODE),
		.CORE_REQ(CORE_REQ), .CORE_WRITE(CORE_WRITE),
		.CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA),
		.CORE_RDATA(CORE_RDATA), .CORE_DONE(CORE_DONE),
		.CORE_ERR(CORE_ERR), .CORE_BUSY(CORE_BUSY), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
		.MEM_RD_EN(MEM_RD_EN), .MEM_WR_EN(MEM_WR_EN),
		.MEM_CS_FLASH(MEM_CS_FLASH), .MEM_CS_EXT(MEM_CS_EXT),
		.MEM_CS_IO(MEM_CS_IO));

	bzd_mem_model mem (.clock(CLOCK), .mem_addr(MEM_ADDR),
		.mem_wdata(MEM_WDATA), .mem_rd_en(MEM_RD_EN),
		.mem_wr_en(MEM_WR_EN), .mem_rdata(MEM_RDATA));

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs about 350 cycles
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 10000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic boot(input logic [2:0] pins, input logic blank);
		@(posedge CLOCK);
		RST_N <= 1'b0;
		BOOT_SELECT_PINS <= pins;
		FLASH_BLANK <= blank;
		repeat (12) @(posedge CLOCK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLOCK);
	endtask

	task automatic reg_wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge CLOCK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask

	task automatic reg_rd(input logic [23:0] a, input logic [15:0] exp);
		@(posedge CLOCK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		check(REG_RDATA, exp);
	endtask

	// One core transfer; len is the cycle count after the request cycle
	task automatic xfer(input logic wr, input logic [23:0] a, input int len,
		input logic [2:0] cs, input logic err);
		int n;
		logic [2:0] seen;
		n = 1;
		seen = 3'h0;
		@(posedge CLOCK);
		CORE_REQ <= 1'b1;
		CORE_WRITE <= wr;
		CORE_ADDR <= a;
		CORE_WDATA <= a[15:0] ^ 16'h1234;
		@(posedge CLOCK);
		CORE_REQ <= 1'b0;
		#1;
		check(CORE_BUSY, !err);
		while (CORE_DONE !== 1'b1 && n < 40) begin
			seen = seen | {MEM_CS_FLASH, MEM_CS_EXT, MEM_CS_IO};
			@(posedge CLOCK);
			#1;
			n++;
		end
		check(n, len + 1);
		check(CORE_ERR, err);
		check(seen, cs);
		if (!err) check(MEM_ADDR, a);
		if (!err && wr) check(mem.last_wdata, a[15:0] ^ 16'h1234);
		if (!err && !wr) check(CORE_RDATA, a[15:0] ^ 16'h5a5a);
	endtask

	task automatic t_modes();
		logic [8:0] tbl [8] = '{9'h1c1, 9'h1f0, 9'h0c2, 9'h0f0, 9'h190,
			9'h024, 9'h068, 9'h090};
		foreach (tbl[i]) begin
			boot(tbl[i][8:6], tbl[i][5]);
			check(OPER_MODE, tbl[i][4:0]);
		end
	endtask

	task automatic t_mode_hold();
		boot(3'h7, 1'b0);
		BOOT_SELECT_PINS <= 3'h0;
		FLASH_BLANK <= 1'b1;
		repeat (5) @(posedge CLOCK);
		check(OPER_MODE, 5'h01);
		reg_rd(REG_STATUS_ADDR, 16'h0001);
	endtask

	task automatic t_defaults();
		reg_rd(REG_GEN_ADDR, 16'h0007);
		reg_rd(REG_SZ1_ADDR, 16'h069f);
		xfer(1'b0, 24'h400000, 12, 3'b010, 1'b0);
		xfer(1'b1, 24'h400002, 13, 3'b010, 1'b0);
	endtask

	task automatic t_regs();
		reg_wr(REG_GEN_ADDR, 16'h0006);
		reg_wr(REG_IOZ_ADDR, 16'h0680);
		reg_wr(REG_SZ0_ADDR, 16'h0680);
		reg_wr(REG_SZ1_ADDR, 16'h068a);
		reg_wr(REG_SZ2_ADDR, 16'h0680);
		reg_wr(24'hfff90c, 16'hffff);
		reg_rd(REG_GEN_ADDR, 16'h0006);
		reg_rd(REG_IOZ_ADDR, 16'h0680);
		reg_rd(REG_SZ0_ADDR, 16'h0680);
		reg_rd(REG_SZ1_ADDR, 16'h068a);
		reg_rd(REG_SZ2_ADDR, 16'h0680);
		reg_rd(24'hfff90c, 16'h0000);
	endtask

	task automatic t_timing();
		xfer(1'b0, 24'h400004, 5, 3'b010, 1'b0);
		xfer(1'b1, 24'h400006, 5, 3'b010, 1'b0);
		reg_wr(REG_SZ1_ADDR, 16'h0680);
		xfer(1'b0, 24'h400008, 2, 3'b010, 1'b0);
		xfer(1'b1, 24'h40000a, 2, 3'b010, 1'b0);
		reg_wr(REG_GEN_ADDR, 16'h0007);
		xfer(1'b1, 24'h40000e, 3, 3'b010, 1'b0);
		reg_wr(REG_GEN_ADDR, 16'h0006);
		reg_wr(REG_SZ1_ADDR, 16'h0e9f);
		xfer(1'b0, 24'h40000c, 1, 3'b010, 1'b0);
		reg_wr(REG_SZ1_ADDR, 16'h0680);
	endtask

	task automatic t_zones();
		logic [27:0] tbl [12] = '{{24'h000000, 4'h8}, {24'h03fffe, 4'h8},
			{24'h400000, 4'h4}, {24'h7ffffe, 4'h4}, {24'h800000, 4'h4},
			{24'hfefffe, 4'h4}, {24'hfffb00, 4'h2}, {24'hfffbfe, 4'h2},
			{24'h040000, 4'h1}, {24'h100000, 4'h1}, {24'hff0000, 4'h1},
			{24'h0e0000, 4'h1}};
		foreach (tbl[i]) begin
			xfer(1'b0, tbl[i][27:4], tbl[i][0] ? 0 : 2, tbl[i][3:1],
				tbl[i][0]);
		end
	endtask

	task automatic t_debug();
		boot(3'h0, 1'b1);
		xfer(1'b0, 24'h000000, 12, 3'b010, 1'b0);
		boot(3'h1, 1'b1);
		xfer(1'b0, 24'h000000, 12, 3'b100, 1'b0);
	endtask

	initial begin
		t_modes();
		t_mode_hold();
		t_defaults();
		t_regs();
		t_timing();
		t_zones();
		t_debug();
		final_report();
	end
endmodule
`default_nettype wire
